// ==== core/ass_scan_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module ass_scan_top (
  input  wire logic                               CLK_SYS,
  input  wire logic                               RESETN,
  input  wire logic [ass_pkg::NUM_CH*ass_pkg::RES_W-1:0] ANALOG_IN,
  input  wire logic                               TRIGGER_PIN,
  input  wire logic [31:0]                        HADDR,
  input  wire logic [1:0]                         HTRANS,
  input  wire logic                               HWRITE,
  input  wire logic [2:0]                         HSIZE,
  input  wire logic [31:0]                        HWDATA,
  input  wire logic                               HSEL,
  input  wire logic                               HREADY,
  output logic [31:0]                             HRDATA,
  output logic                                    HREADYOUT,
  output logic                                    HRESP,
  output logic                                    IRQ
);
  import ass_pkg::*;

  typedef enum {S_IDLE, S_ARM, S_CONV, S_WAIT} ass_state_t;

  ass_conv_if cv();
  ass_convert u_conv (
    .clk    (CLK_SYS),
    .rst_n  (RESETN),
    .analog (ANALOG_IN),
    .cv     (cv)
  );

  // ==========================================================
  // Trigger pin synchroniser
  logic [2:0] trg_sync_q;
  logic       trg_lvl_q;
  logic       trg_rise;
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      trg_sync_q <= 3'h0;
      trg_lvl_q  <= 1'b0;
    end else begin
      trg_sync_q <= {trg_sync_q[1:0], TRIGGER_PIN};
      if (trg_sync_q[1] == trg_sync_q[2]) begin
        trg_lvl_q <= trg_sync_q[2];
      end
    end
  end

  // ==========================================================
  // AHB-Lite slave, zero wait states
  logic        wr_pend_q, wr_pend_d;
  logic        rd_pend_d;
  logic [7:0]  addr_q, addr_d;
  logic        acc;
  logic        start_q, start_d;
  logic        scan_q, scan_d, trg_en_q, trg_en_d;
  logic [1:0]  time_q, time_d;
  logic        end_q, end_d, irq_en_q, irq_en_d;
  logic [9:0]  res_q [NUM_CH];
  logic [9:0]  res_d [NUM_CH];
  logic [31:0] rdata_d, rdata_q;
  logic        trg_prev_q;
  ass_state_t  st_q, st_d;
  logic [1:0]  ch_q, ch_d;
  logic        go;
  logic        scan_end;

  assign acc      = HSEL && HREADY && HTRANS[1];
  assign trg_rise = trg_lvl_q && !trg_prev_q;
  assign go       = trg_en_q && trg_rise;

  always_comb begin
    wr_pend_d = acc && HWRITE;
    rd_pend_d = acc && !HWRITE;
    addr_d    = acc ? HADDR[7:0] : addr_q;
    start_d   = start_q;
    scan_d    = scan_q;
    trg_en_d  = trg_en_q;
    time_d    = time_q;
    irq_en_d  = irq_en_q;
    end_d     = end_q;
    if (st_q == S_IDLE && go) begin
      start_d = 1'b1;
    end
    if (wr_pend_q && addr_q == ADDR_CTRL) begin
      start_d  = HWDATA[CTRL_START_BIT];
      scan_d   = HWDATA[CTRL_SCAN_BIT];
      trg_en_d = HWDATA[CTRL_TRG_BIT];
      time_d   = HWDATA[CTRL_TIME_LSB +: 2] & CTRL_WMASK_TIME;
    end
    if (wr_pend_q && addr_q == ADDR_IRQ_EN) begin
      irq_en_d = HWDATA[STAT_END_BIT];
    end
    if (wr_pend_q && addr_q == ADDR_CLEAR && HWDATA[STAT_END_BIT]) begin
      end_d = 1'b0;
    end
    if (scan_end) begin
      end_d = 1'b1;
    end
    if (scan_end && !scan_q) begin
      start_d = 1'b0;
    end
    rdata_d = 32'h0000_0000;
    if (rd_pend_d) begin
      unique case (HADDR[7:0])
        ADDR_CTRL:   rdata_d = {26'h0, time_q, 1'b0, trg_en_q, scan_q, start_q};
        ADDR_STATUS: rdata_d = {23'h0, (st_q != S_IDLE), 7'h0, end_q};
        ADDR_IRQ_EN: rdata_d = {31'h0, irq_en_q};
        ADDR_RES_A:  rdata_d = {22'h0, res_q[0]};
        ADDR_RES_B:  rdata_d = {22'h0, res_q[1]};
        ADDR_RES_C:  rdata_d = {22'h0, res_q[2]};
        ADDR_RES_D:  rdata_d = {22'h0, res_q[3]};
        default:     rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // Scan sequencer
  always_comb begin
    st_d     = st_q;
    ch_d     = ch_q;
    scan_end = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      res_d[i] = res_q[i];
    end
    unique case (st_q)
      S_IDLE: begin
        ch_d = 2'h0;
        if (start_q) begin
          st_d = S_ARM;
        end
      end
      S_ARM: begin
        st_d = S_CONV;
      end
      S_CONV: begin
        st_d = S_WAIT;
      end
      S_WAIT: begin
        if (cv.done) begin
          res_d[ch_q] = cv.result;
          if (ch_q == 2'h3 || !scan_q) begin
            scan_end = 1'b1;
            ch_d     = 2'h0;
            st_d     = (scan_q && start_q) ? S_CONV : S_IDLE;
          end else begin
            ch_d = ch_q + 2'h1;
            st_d = S_CONV;
          end
        end
      end
    endcase
  end

  assign cv.start  = (st_q == S_CONV);
  assign cv.ch     = ch_q;
  assign cv.cycles = (time_q == 2'h0) ? CONV_T0 :
                     (time_q == 2'h1) ? CONV_T1 :
                     (time_q == 2'h2) ? CONV_T2 : CONV_T3;

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      wr_pend_q  <= 1'b0;
      addr_q     <= 8'h00;
      start_q    <= CTRL_RESET[CTRL_START_BIT];
      scan_q     <= 1'b0;
      trg_en_q   <= 1'b0;
      time_q     <= 2'h0;
      irq_en_q   <= 1'b0;
      end_q      <= 1'b0;
      rdata_q    <= 32'h0000_0000;
      trg_prev_q <= 1'b0;
      st_q       <= S_IDLE;
      ch_q       <= 2'h0;
      for (int i = 0; i < NUM_CH; i++) begin
        res_q[i] <= 10'h000;
      end
    end else begin
      wr_pend_q  <= wr_pend_d;
      addr_q     <= addr_d;
      start_q    <= start_d;
      scan_q     <= scan_d;
      trg_en_q   <= trg_en_d;
      time_q     <= time_d;
      irq_en_q   <= irq_en_d;
      end_q      <= end_d;
      rdata_q    <= rdata_d;
      trg_prev_q <= trg_lvl_q;
      st_q       <= st_d;
      ch_q       <= ch_d;
      for (int i = 0; i < NUM_CH; i++) begin
        res_q[i] <= res_d[i];
      end
    end
  end

  assign HRDATA    = rdata_q;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign IRQ       = end_q && irq_en_q;

  // ==========================================================
  // Checks
  chk_end_sets: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    scan_end |=> end_q) else $error("End flag not set after scan.");
  chk_end_sticky: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    end_q && !(wr_pend_q && addr_q == ADDR_CLEAR) |=> end_q) else $error("End flag lost.");
  chk_irq_level: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    scan_end && irq_en_q && !(wr_pend_q && addr_q == ADDR_IRQ_EN) |=> IRQ)
    else $error("Interrupt not raised at scan end.");
  chk_trig_start: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    st_q == S_IDLE && go && !wr_pend_q |=> start_q ##1 st_q == S_ARM)
    else $error("Trigger did not start scan.");
  chk_ch_order: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    st_q == S_WAIT && cv.done && scan_q && ch_q != 2'h3 |=> ch_q == $past(ch_q) + 2'h1)
    else $error("Channel order broken.");
  chk_res_store: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    st_q == S_WAIT && cv.done |=> res_q[$past(ch_q)] == $past(cv.result))
    else $error("Result not stored.");
  chk_repeat: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    scan_end && scan_q && start_q |=> st_q == S_CONV) else $error("Scan did not repeat.");
  chk_conv_len: assert property (@(posedge CLK_SYS) disable iff (!RESETN)
    cv.start && time_q == 2'h1 |-> ##[128:130] cv.done) else $error("Conversion time wrong.");
endmodule
`default_nettype wire

// ==== shared/ass_pkg.sv ====
`default_nettype none
package ass_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_CLEAR   = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN  = 8'h0C;
  localparam logic [7:0] ADDR_RES_A   = 8'h10;
  localparam logic [7:0] ADDR_RES_B   = 8'h14;
  localparam logic [7:0] ADDR_RES_C   = 8'h18;
  localparam logic [7:0] ADDR_RES_D   = 8'h1C;
  // ==========================================================
  // Control and status fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_SCAN_BIT  = 1;
  localparam int CTRL_TRG_BIT   = 2;
  localparam int CTRL_TIME_LSB  = 4;
  localparam int STAT_END_BIT   = 0;
  localparam int STAT_BUSY_BIT  = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0]  CTRL_WMASK_TIME = 2'h3;
  // ==========================================================
  // Conversion times in clock cycles, index by time field
  localparam logic [9:0] CONV_T0 = 10'h100;
  localparam logic [9:0] CONV_T1 = 10'h080;
  localparam logic [9:0] CONV_T2 = 10'h040;
  localparam logic [9:0] CONV_T3 = 10'h200;
  localparam int NUM_CH  = 4;
  localparam int RES_W   = 10;
endpackage
`default_nettype wire

// ==== shared/ass_conv_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface ass_conv_if;
  logic       start;
  logic [1:0] ch;
  logic [9:0] cycles;
  logic       done;
  logic [9:0] result;
  modport ctrl (output start, output ch, output cycles, input done, input result);
  modport conv (input start, input ch, input cycles, output done, output result);
endinterface
`default_nettype wire

// ==== core/ass_convert.sv ====
`timescale 1ns/100ps
`default_nettype none
module ass_convert (
  input  wire logic                                      clk,
  input  wire logic                                      rst_n,
  input  wire logic [ass_pkg::NUM_CH*ass_pkg::RES_W-1:0] analog,
  ass_conv_if.conv                                       cv
);
  import ass_pkg::*;
  // ==========================================================
  // Count-then-sample converter model of one channel at a time
  logic [9:0] cnt_q, cnt_d;
  logic       busy_q, busy_d, done_q, done_d;
  logic [9:0] res_q, res_d;

  always_comb begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    res_d  = res_q;
    if (!busy_q && cv.start) begin
      busy_d = 1'b1;
      cnt_d  = cv.cycles - 10'h001;
    end else if (busy_q) begin
      if (cnt_q == 10'h000) begin
        busy_d = 1'b0;
        done_d = 1'b1;
        res_d  = analog[cv.ch*RES_W +: RES_W];
      end else begin
        cnt_d = cnt_q - 10'h001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 10'h000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      res_q  <= 10'h000;
    end else begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
      res_q  <= res_d;
    end
  end

  assign cv.done   = done_q;
  assign cv.result = res_q;
endmodule
`default_nettype wire

// ==== verif/ass_trig_src.sv ====
`timescale 1ns/100ps
`default_nettype none
// ====================================================
// External trigger source.
module ass_trig_src (
  input  wire logic clk,
  input  wire logic fire,
  output logic      trig
);
  logic [2:0] cnt_q = 3'h0;
  // The pulse is held long enough for the three-stage synchroniser to see it.
  always @(posedge clk) begin
    if (fire) begin
      cnt_q <= 3'h6;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
  assign trig = (cnt_q != 3'h0);
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
  import ass_pkg::*;
  logic        clk, rst_n, fire, trig, hwrite, irq, hrdy, hresp;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [39:0] an, prev;
  int          err_count, checked, cyc, n, i;
  ass_trig_src u_ass_trig_src (.clk(clk), .fire(fire), .trig(trig));
  ass_scan_top u_ass_scan_top (.CLK_SYS(clk), .RESETN(rst_n), .ANALOG_IN(an),
    .TRIGGER_PIN(trig), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HSEL(1'b1), .HREADY(hrdy), .HRDATA(hrdata),
    .HREADYOUT(hrdy), .HRESP(hresp), .IRQ(irq));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ====================================================
  // Expectations and bus cycles.
  function automatic logic [31:0] res_of(logic [39:0] a, int k);
    return {22'h0, a[k*10 +: 10]};
  endfunction
  function automatic logic [39:0] rnd_an();
    logic [63:0] r;
    r = {$urandom, $urandom};
    return r[39:0];
  endfunction
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
    `CHK(hresp, 1'b0)
  endtask
  task automatic wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic pulse();
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
  endtask
  task summarize;
    $display("Mismatches %0d, comparisons %0d", err_count, checked);
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // A scan at the 256-cycle setting takes about 1050 cycles; six fit well.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      err_count++;
      summarize;
    end
  end
  // ====================================================
  // Main sequence.
  initial begin
    rst_n = 1'b0;
    fire = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    an = 40'h0;
    void'($urandom(32'hD1D0));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    an <= rnd_an();
    `CHK(irq, 1'b0)
    rchk(ADDR_CTRL, CTRL_RESET);
    rchk(ADDR_STATUS, 32'h0);
    rchk(8'h20, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h2);
    pulse();
    repeat (300) @(posedge clk);
    rchk(ADDR_STATUS, 32'h0);
    bus(1'b1, ADDR_IRQ_EN, 32'h1);
    bus(1'b1, ADDR_CTRL, 32'h6);
    pulse();
    wait_irq(2000);
    `CHK(n >= 1024 && n < 1200, 1'b1)
    bus(1'b0, ADDR_STATUS, 32'h0);
    `CHK(rd[STAT_END_BIT], 1'b1)
    bus(1'b0, ADDR_CTRL, 32'h0);
    `CHK(rd[CTRL_START_BIT], 1'b1)
    prev = an;
    an <= rnd_an();
    bus(1'b1, ADDR_CLEAR, 32'h1);
    @(posedge clk);
    `CHK(irq, 1'b0)
    for (i = 0; i < NUM_CH; i++) begin
      rchk(ADDR_RES_A + 8'(i*4), res_of(prev, i));
    end
    wait_irq(1200);
    `CHK(irq, 1'b1)
    bus(1'b1, ADDR_CTRL, 32'h6);
    bus(1'b1, ADDR_CLEAR, 32'h1);
    for (i = 0; i < NUM_CH; i++) begin
      rchk(ADDR_RES_A + 8'(i*4), res_of(an, i));
    end
    // The scan under way when start is cleared still runs to its end.
    wait_irq(1200);
    `CHK(irq, 1'b1)
    bus(1'b1, ADDR_CLEAR, 32'h1);
    repeat (1500) @(posedge clk);
    rchk(ADDR_STATUS, 32'h0);
    bus(1'b1, ADDR_IRQ_EN, 32'h0);
    an <= rnd_an();
    bus(1'b1, ADDR_CTRL, 32'h11);
    n = 0;
    do begin
      bus(1'b0, ADDR_STATUS, 32'h0);
      n++;
    end while (rd[STAT_END_BIT] !== 1'b1 && n < 200);
    `CHK(rd[STAT_END_BIT], 1'b1)
    `CHK(n > 40 && n < 60, 1'b1)
    `CHK(irq, 1'b0)
    rchk(ADDR_RES_A, res_of(an, 0));
    bus(1'b1, ADDR_IRQ_EN, 32'h1);
    @(posedge clk);
    `CHK(irq, 1'b1)
    summarize;
  end
endmodule
`default_nettype wire
